// file: rtl/sio_i2c_ctl.sv
// serial port core: bit counter, wait, acknowledge and interrupt condition
//
// Behaviour
// - raise the serial interrupt flag when the selected condition comes true
// - select 00 count 7, 01 count 8, 10 first 7 after start, 11 stop
// - selecting count 7 or 8 while counter holds it requests at once
// - after-start with start seen at 7, or stop mode after stop, requests
// - counter starts at 0 and counts each detected clock pin rise while running
// - counter wraps after 9 in two-wire bus mode, after 8 otherwise
// - counter cleared by reset, clock stop, start and leaving bus mode
// - released port shifts data until the chosen wait condition is met
// - on wait in bus mode hold clock low, halt counter and shifter
// - forced wait takes effect at the clock fall after the write
// - re-release changes nothing; forced wait during wait gives one pulse
// - master stalls while another station holds the clock low
// - acknowledge logic works only in bus mode, driven or captured
// - receiving: drive the ack bit on the fall at count 8, keep it
// - transmitting: sample data line into ack bit as count reaches 9
// - writing the ack bit also writes the release flag
// - bus master in wait holds the clock pin low
// - forced wait halts counter; issued while clock low, one more pulse
// - release flag 1 starts, 0 forces wait, read shows transfer status
// - detect start and stop into start-seen and bus-busy flags
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`include "sio_params.svh"

module sio_i2c_ctl #(
   parameter int unsigned HALF_CYC = `SIO_SCL_HALF_CYC
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  clk_en,
   input  wire sio_pkg::sio_reg_req_t reg_req,
   output logic [3:0]                 reg_rdata,
   input  wire logic                  irq_ack,
   output logic                       serial_irq_flag,
   input  wire logic                  scl_in,
   output logic                       scl_out,
   output logic                       scl_oe,
   input  wire logic                  sda_in,
   output logic                       sda_out,
   output logic                       sda_oe
);
   import sio_pkg::*;

   // the phase counter needs at least two cycles per half period
   if (HALF_CYC < 2) begin : g_chk
      $error("HALF_CYC must be at least 2");
   end

   localparam int unsigned PW = $clog2(HALF_CYC);

   // decode of the interrupt issuance condition for a counter value
   function automatic logic irq_cond(input logic [1:0] sel,
                                     input logic [3:0] c,
                                     input logic       st,
                                     input logic       i2c,
                                     input logic       stp);
      logic r;
      r = 1'b0;
      case (sel)
         2'h0: r = (c == `SIO_CNT_SEVEN);
         2'h1: r = (c == `SIO_CNT_EIGHT);
         2'h2: r = i2c & st & (c == `SIO_CNT_SEVEN);
         2'h3: r = i2c & stp;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic        i2c_mode, master, transmit;
   logic [1:0]  irq_sel;
   logic [1:0]  wait_sel;
   logic        wait_release_flag, ack_bit;
   logic        force_pend, force_halt, pulse_req;
   logic        start_seen_flag, bus_busy_flag, stop_seen, first7, addr_byte;
   logic [3:0]  cnt;
   logic [7:0]  serial_shift_reg;
   sio_gen_t    gen_st;
   logic [PW-1:0] ph;

   logic        wr_wait, wr_sel, wr_cfg, wr_irq, clk_stop, mode_drop;
   logic        rise_ev, fall_ev, start_ev, stop_ev;
   logic        run, cnt_inc, wait_hit, ack_cap, irq_set, irq_clr;
   logic        gen_on, ph_end, wstt, next_scl_oe;
   logic [3:0]  cnt_max, next_cnt_inc, next_rdata;
   logic [3:0]  wd;

   // pin synchronisers; idle bus lines read high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else if (clk_en) begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   // access decode and line events
   always_comb begin
      wd        = reg_req.wdata;
      wr_wait   = reg_req.wr & (reg_req.addr == `SIO_OFF_WAIT_CTL);
      wr_sel    = reg_req.wr & (reg_req.addr == `SIO_OFF_IRQ_SEL);
      wr_cfg    = reg_req.wr & (reg_req.addr == `SIO_OFF_CFG);
      wr_irq    = reg_req.wr & (reg_req.addr == `SIO_OFF_IRQ);
      clk_stop  = wr_cfg & wd[`SIO_CFG_CLK_STOP];
      mode_drop = wr_cfg & i2c_mode & ~wd[`SIO_CFG_I2C];
      rise_ev   = scl_s & ~scl_d;
      fall_ev   = ~scl_s & scl_d;
      // data line moving while clock stays high marks start or stop
      start_ev  = i2c_mode & scl_s & scl_d & sda_d & ~sda_s;
      stop_ev   = i2c_mode & scl_s & scl_d & ~sda_d & sda_s;
      cnt_max   = i2c_mode ? `SIO_CNT_I2C_MAX : `SIO_CNT_SIO_MAX;
      // counter and shifter run while released and not halted, or for a single pulse
      run       = (wait_release_flag & ~force_halt) | pulse_req;
      cnt_inc   = rise_ev & run & ~start_ev;
      next_cnt_inc = (cnt == cnt_max) ? 4'h1 : cnt + 4'h1;
      ack_cap   = i2c_mode & transmit & cnt_inc
                  & (cnt == `SIO_CNT_EIGHT);
   end

   // wait condition match, bus mode at clock falls, serial mode at rises and forced wait at falls
   always_comb begin
      wait_hit = 1'b0;
      if (wait_release_flag) begin
         if (i2c_mode) begin
            if (fall_ev) begin
               case (sio_wait_t'(wait_sel))
                  SIO_WAIT_DATA: wait_hit = (cnt == `SIO_CNT_EIGHT);
                  SIO_WAIT_ACK:  wait_hit = (cnt == `SIO_CNT_NINE);
                  SIO_WAIT_ADDR: wait_hit = (cnt == `SIO_CNT_EIGHT)
                                            & addr_byte;
                  default:       wait_hit = 1'b0;
               endcase
               wait_hit = wait_hit | force_pend;
            end
         end else begin
            wait_hit = (fall_ev & force_pend)
                     | (cnt_inc & (cnt == `SIO_CNT_SEVEN)
                        & (wait_sel == SIO_WAIT_DATA));
         end
      end
   end

   // configuration of mode, role and direction
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         i2c_mode <= 1'b0;
         master   <= 1'b0;
         transmit <= 1'b0;
      end else if (clk_en && wr_cfg) begin
         i2c_mode <= wd[`SIO_CFG_I2C];
         master   <= wd[`SIO_CFG_MASTER];
         transmit <= wd[`SIO_CFG_TX];
      end
   end

   // interrupt condition selection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_sel <= 2'h0;
      end else if (clk_en) begin
         if (clk_stop) begin
            irq_sel <= 2'h0;
         end else if (wr_sel) begin
            irq_sel <= wd[1:0];
         end
      end
   end

   // wait control: release, forced wait, single pulse, ack bit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wait_sel          <= 2'h0;
         wait_release_flag <= 1'b0;
         ack_bit           <= 1'b0;
         force_pend        <= 1'b0;
         force_halt        <= 1'b0;
         pulse_req         <= 1'b0;
      end else if (clk_en) begin
         if (clk_stop) begin
            wait_sel          <= 2'h0;
            wait_release_flag <= 1'b0;
            ack_bit           <= 1'b0;
            force_pend        <= 1'b0;
            force_halt        <= 1'b0;
            pulse_req         <= 1'b0;
         end else if (wr_wait) begin
            // ack and release share one word, so both are written
            wait_sel <= wd[1:0];
            ack_bit  <= wd[`SIO_WCT_ACK];
            if (wd[`SIO_WCT_RELEASE]) begin
               wait_release_flag <= 1'b1;
            end else if (wait_release_flag) begin
               // halt now if the clock is high, else after one more rise
               force_pend <= 1'b1;
               force_halt <= scl_s;
            end else begin
               pulse_req <= 1'b1;
            end
         end else begin
            if (ack_cap) begin
               ack_bit <= sda_s;
            end
            if (wait_hit) begin
               wait_release_flag <= 1'b0;
               force_pend        <= 1'b0;
               force_halt        <= 1'b0;
            end else if (force_pend && rise_ev) begin
               force_halt <= 1'b1;
            end
            if (pulse_req && fall_ev) begin
               pulse_req <= 1'b0;
            end
         end
      end
   end

   // bit counter; a count of max drops to 0 at the fall unless waiting
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
      end else if (clk_en) begin
         if (clk_stop || start_ev || mode_drop) begin
            cnt <= 4'h0;
         end else if (cnt_inc) begin
            cnt <= next_cnt_inc;
         end else if (fall_ev && run && !wait_hit && cnt == cnt_max) begin
            cnt <= 4'h0;
         end
      end
   end

   // start and stop bookkeeping, all zero outside bus mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_seen_flag <= 1'b0;
         bus_busy_flag   <= 1'b0;
         stop_seen       <= 1'b0;
         first7          <= 1'b0;
         addr_byte       <= 1'b0;
      end else if (clk_en) begin
         if (clk_stop || !i2c_mode) begin
            start_seen_flag <= 1'b0;
            bus_busy_flag   <= 1'b0;
            stop_seen       <= 1'b0;
            first7          <= 1'b0;
            addr_byte       <= 1'b0;
         end else if (start_ev) begin
            start_seen_flag <= 1'b1;
            bus_busy_flag   <= 1'b1;
            stop_seen       <= 1'b0;
            first7          <= 1'b1;
            addr_byte       <= 1'b1;
         end else if (stop_ev) begin
            start_seen_flag <= 1'b0;
            bus_busy_flag   <= 1'b0;
            stop_seen       <= 1'b1;
         end else begin
            if (cnt_inc && next_cnt_inc == `SIO_CNT_SEVEN) begin
               first7 <= 1'b0;
            end
            if (fall_ev && cnt == `SIO_CNT_NINE) begin
               addr_byte <= 1'b0;
            end
         end
      end
   end

   // interrupt events: counter rise, stop, or selection written late
   always_comb begin
      irq_set = irq_cond(irq_sel, cnt_inc ? next_cnt_inc : 4'hf,
                         first7, i2c_mode, stop_ev);
      if (wr_sel) begin
         // a late selection may fire at once, hence the wait advice
         irq_set = irq_set | irq_cond(wd[1:0], cnt, start_seen_flag,
                                      i2c_mode, stop_seen);
      end
      irq_clr = irq_ack | (wr_irq & ~wd[0]);
   end

   // sticky request flag; a set in the clearing cycle wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         serial_irq_flag <= 1'b0;
      end else if (clk_en) begin
         if (irq_set) begin
            serial_irq_flag <= 1'b1;
         end else if (irq_clr) begin
            serial_irq_flag <= 1'b0;
         end
      end
   end

   // shift register: load by nibbles, shift in on counted rises
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         serial_shift_reg <= `SIO_RST_SHIFT;
      end else if (clk_en) begin
         if (reg_req.wr && reg_req.addr == `SIO_OFF_SHIFT_LO) begin
            serial_shift_reg[3:0] <= wd;
         end else if (reg_req.wr && reg_req.addr == `SIO_OFF_SHIFT_HI) begin
            serial_shift_reg[7:4] <= wd;
         end else if (cnt_inc && cnt < `SIO_CNT_EIGHT) begin
            serial_shift_reg <= {serial_shift_reg[6:0], sda_s};
         end
      end
   end

   // master clock generator; high phase only counts while the line is high
   always_comb begin
      // stop at the wait fall itself, else a stray high half slips out
      gen_on = master & ((wait_release_flag & ~wait_hit)
                         | (pulse_req & ~fall_ev));
      ph_end = (ph == PW'(HALF_CYC - 1));
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gen_st <= SIO_GEN_IDLE;
         ph     <= '0;
      end else if (clk_en) begin
         case (gen_st)
            SIO_GEN_IDLE: begin
               ph <= '0;
               if (gen_on) begin
                  gen_st <= SIO_GEN_LOW;
               end
            end
            SIO_GEN_LOW: begin
               if (!gen_on) begin
                  gen_st <= SIO_GEN_IDLE;
                  ph     <= '0;
               end else if (ph_end) begin
                  gen_st <= SIO_GEN_HIGH;
                  ph     <= '0;
               end else begin
                  ph <= ph + 1'b1;
               end
            end
            SIO_GEN_HIGH: begin
               if (!gen_on) begin
                  gen_st <= SIO_GEN_IDLE;
                  ph     <= '0;
               end else if (scl_s) begin
                  if (ph_end) begin
                     gen_st <= SIO_GEN_LOW;
                     ph     <= '0;
                  end else begin
                     ph <= ph + 1'b1;
                  end
               end
            end
            default: begin
               gen_st <= SIO_GEN_IDLE;
               ph     <= '0;
            end
         endcase
      end
   end

   // clock pin: bus mode holds low in wait, serial mode idles high
   always_comb begin
      if (i2c_mode) begin
         next_scl_oe = master ? (gen_st != SIO_GEN_HIGH)
                     : (~wait_release_flag & ~pulse_req
                        & bus_busy_flag);
      end else begin
         next_scl_oe = master & (gen_st == SIO_GEN_LOW);
      end
   end

   // pin drivers; open drain, so the driven level is always low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_oe  <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else if (clk_en) begin
         scl_oe <= next_scl_oe;
      end
   end

   // data line: data bits at falls, ack at the fall of count 8
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sda_oe <= 1'b0;
      end else if (clk_en) begin
         if (clk_stop) begin
            sda_oe <= 1'b0;
         end else if (wr_wait && wd[`SIO_WCT_RELEASE] && !wait_release_flag
                      && transmit && cnt != `SIO_CNT_EIGHT) begin
            sda_oe <= ~serial_shift_reg[7];
         end else if (fall_ev && (wait_release_flag || pulse_req)) begin
            if (i2c_mode && cnt == `SIO_CNT_EIGHT) begin
               // receiver drives ack, transmitter lets the line go
               sda_oe <= ~transmit & ~ack_bit;
            end else begin
               sda_oe <= transmit & ~serial_shift_reg[7];
            end
         end
      end
   end

   // read data, valid in the cycle after the read strobe
   always_comb begin
      wstt = wait_release_flag
             & ~(master & (gen_st == SIO_GEN_HIGH) & ~scl_s);
      next_rdata = 4'h0;
      case (reg_req.addr)
         `SIO_OFF_SHIFT_LO:  next_rdata = serial_shift_reg[3:0];
         `SIO_OFF_SHIFT_HI:  next_rdata = serial_shift_reg[7:4];
         `SIO_OFF_CFG:       next_rdata = {1'b0, transmit, master, i2c_mode};
         `SIO_OFF_IRQ:       next_rdata = {3'h0, serial_irq_flag};
         `SIO_OFF_WAIT_STAT: next_rdata = {3'h0, wstt};
         `SIO_OFF_IRQ_SEL:   next_rdata = {2'h0, irq_sel};
         `SIO_OFF_STATUS:    next_rdata = {start_seen_flag, bus_busy_flag,
                                           cnt == `SIO_CNT_EIGHT,
                                           cnt == `SIO_CNT_NINE};
         `SIO_OFF_WAIT_CTL:  next_rdata = {ack_bit, wait_release_flag,
                                           wait_sel};
         default:            next_rdata = 4'h0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `SIO_RST_NIBBLE;
      end else if (clk_en) begin
         reg_rdata <= reg_req.rd ? next_rdata : 4'h0;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_irq_sticky;
      clk_en && serial_irq_flag && !irq_ack && !wr_irq |=> serial_irq_flag;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("interrupt flag dropped without a clear");

   property p_irq_cnt7;
      clk_en && irq_sel == 2'h0 && cnt_inc && next_cnt_inc == 4'h7
      |=> serial_irq_flag;
   endproperty
   a_irq_cnt7: assert property (p_irq_cnt7)
      else $error("no interrupt as counter reached 7");

   property p_irq_late_sel;
      clk_en && wr_sel && wd[1:0] == 2'h1 && cnt == 4'h8
      |=> serial_irq_flag;
   endproperty
   a_irq_late_sel: assert property (p_irq_late_sel)
      else $error("late selection at count 8 did not request");

   property p_cnt_range;
      (i2c_mode && cnt <= 4'h9) || (!i2c_mode && cnt <= 4'h8);
   endproperty
   a_cnt_range: assert property (p_cnt_range)
      else $error("bit counter out of range");

   property p_cnt_step;
      clk_en && cnt_inc && !clk_stop && !mode_drop && cnt < 4'h8
      |=> cnt == $past(cnt) + 4'h1;
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("counter did not step on a clock rise");

   property p_start_clr;
      clk_en && start_ev |=> cnt == 4'h0 && start_seen_flag && bus_busy_flag;
   endproperty
   a_start_clr: assert property (p_start_clr)
      else $error("start did not clear the counter");

   property p_ack_cap;
      clk_en && ack_cap && !wr_wait && !clk_stop |=> ack_bit == $past(sda_s);
   endproperty
   a_ack_cap: assert property (p_ack_cap)
      else $error("acknowledge not sampled at count 9");

   property p_ack_drive;
      clk_en && i2c_mode && !transmit && fall_ev && wait_release_flag
      && cnt == 4'h8 && !clk_stop && !wr_wait |=> sda_oe == !ack_bit;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("acknowledge not driven at count 8");

   property p_wait_hold;
      clk_en && i2c_mode && master && !gen_on ##1 clk_en
      |=> scl_oe [*2];
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("master in wait let the clock go");

   property p_serial_flags;
      clk_en && !i2c_mode |=> !start_seen_flag && !bus_busy_flag;
   endproperty
   a_serial_flags: assert property (p_serial_flags)
      else $error("bus flags set outside bus mode");

   cover property (clk_en && wait_hit && i2c_mode);
   cover property (clk_en && start_ev ##[1:1000] stop_ev);
   cover property (clk_en && ack_cap);
   cover property (clk_en && wr_wait && !wd[2] && !wait_release_flag);
endmodule

// file: rtl/sio_params.svh
// register offsets, reset values and timing counts of the serial port
`ifndef SIO_PARAMS_SVH
`define SIO_PARAMS_SVH

// register offsets on the 4-bit register port
`define SIO_OFF_SHIFT_LO   4'h2
`define SIO_OFF_SHIFT_HI   4'h3
`define SIO_OFF_CFG        4'h8
`define SIO_OFF_IRQ        4'h9
`define SIO_OFF_WAIT_STAT  4'ha
`define SIO_OFF_IRQ_SEL    4'hc
`define SIO_OFF_STATUS     4'hd
`define SIO_OFF_WAIT_CTL   4'he

// field positions
`define SIO_CFG_I2C        0
`define SIO_CFG_MASTER     1
`define SIO_CFG_TX         2
`define SIO_CFG_CLK_STOP   3
`define SIO_WCT_RELEASE    2
`define SIO_WCT_ACK        3

// reset values
`define SIO_RST_NIBBLE     4'h0
`define SIO_RST_SHIFT      8'h00

// bit counter landmarks
`define SIO_CNT_I2C_MAX    4'h9
`define SIO_CNT_SIO_MAX    4'h8
`define SIO_CNT_SEVEN      4'h7
`define SIO_CNT_EIGHT      4'h8
`define SIO_CNT_NINE       4'h9

// shift clock half period
`define SIO_CLK_MHZ        20
`define SIO_SCL_HALF_NS    200
`define SIO_SCL_HALF_CYC   ((`SIO_SCL_HALF_NS * `SIO_CLK_MHZ) / 1000)

`endif

// file: rtl/sio_pkg.sv
// types shared by the serial port design
package sio_pkg;

   // register port request, one cycle per access
   typedef struct packed {
      logic [3:0] addr;
      logic [3:0] wdata;
      logic       wr;
      logic       rd;
   } sio_reg_req_t;

   // wait condition codes
   typedef enum logic [1:0] {
      SIO_WAIT_NONE = 2'h0,
      SIO_WAIT_DATA = 2'h1,
      SIO_WAIT_ACK  = 2'h2,
      SIO_WAIT_ADDR = 2'h3
   } sio_wait_t;

   // shift clock generator states, one-hot
   typedef enum logic [2:0] {
      SIO_GEN_IDLE = 3'h1,
      SIO_GEN_LOW  = 3'h2,
      SIO_GEN_HIGH = 3'h4
   } sio_gen_t;

endpackage

// file: sim/serial_port_i2c_wait_ack_irq_test.sv
// self-checking bench for the serial port core
`timescale 1ns/1ns
module serial_port_i2c_wait_ack_irq_test;
   import sio_pkg::*;
   logic         sys_clk, rst, irq_ack, stretch, irq;
   logic         scl_oe, sda_oe, scl, sda;
   logic [1:0]   drv;
   sio_reg_req_t req;
   logic [3:0]   rdata, d;
   logic [7:0]   tx;
   int           fail_count, samples_checked, seed;
   sio_i2c_ctl DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
      .reg_req(req), .reg_rdata(rdata), .irq_ack(irq_ack),
      .serial_irq_flag(irq), .scl_in(scl), .scl_out(drv[1]), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(drv[0]), .sda_oe(sda_oe));
   sio_bus_model bus (.rst(rst), .scl_oe(scl_oe), .sda_oe(sda_oe),
      .stretch(stretch), .scl(scl), .sda(sda));
   // compare one nibble and keep score
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // register port cycles, read data sampled mid-cycle after the strobe
   task automatic wr(input logic [3:0] a, input logic [3:0] v);
      @(posedge sys_clk) req <= '{a, v, 1'b1, 1'b0};
      @(posedge sys_clk) req <= '0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [3:0] v);
      @(posedge sys_clk) req <= '{a, 4'h0, 1'b0, 1'b1};
      @(posedge sys_clk) req <= '0;
      @(negedge sys_clk) v = rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [3:0] e);
      rd(a, d);
      chk(d, e);
   endtask
   // status nibble for a counter value, bus flags idle
   function automatic logic [3:0] st(input int c);
      return {2'b00, c == 8, c == 9};
   endfunction
   // poll the release flag until wait; bounded so a hang shows as a mismatch
   // the status word at 0xa also reads 0 while a driven high is in transit
   task automatic idle();
      d = 4'h4;
      for (int i = 0; i < 80 && d[2]; i++) rd(4'he, d);
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (6000) @(posedge sys_clk);
      fail_count++;
      end_of_test();
   end
   // main sequence
   initial begin
      {rst, irq_ack, stretch} = 3'b100;
      req = '0;
      fail_count = 0;
      samples_checked = 0;
      seed = 32'h69d2b49d;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rc(4'hc, 4'h0);
      rc(4'h9, 4'h0);
      wr(4'h1, 4'hf);
      rc(4'h1, 4'h0);
      $display("done: reset values");
      tx = 8'($random(seed));
      wr(4'h8, 4'h7);
      wr(4'h2, tx[3:0]);
      wr(4'h3, tx[7:4]);
      wr(4'hc, 4'h0);
      wr(4'he, 4'h5);
      for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge sys_clk);
      chk({3'b000, irq}, 4'h1);
      idle();
      rc(4'hd, st(8));
      chk({3'b000, scl_oe}, 4'h1);
      chk({2'b00, drv}, 4'h0);
      wr(4'h9, 4'h0);
      rc(4'h9, 4'h0);
      wr(4'hc, 4'h1);
      rc(4'h9, 4'h1);
      @(posedge sys_clk) irq_ack <= 1'b1;
      @(posedge sys_clk) irq_ack <= 1'b0;
      rc(4'h9, 4'h0);
      $display("done: data wait and interrupt");
      // ack wait next, so data wait is never set twice in a row
      wr(4'he, 4'he);
      stretch <= 1'b1;
      // held low from outside: still released, but reported as waiting
      repeat (10) @(posedge sys_clk);
      rc(4'ha, 4'h0);
      rc(4'he, 4'he);
      @(posedge sys_clk) stretch <= 1'b0;
      idle();
      rc(4'hd, st(9));
      rc(4'he, 4'h2);
      $display("done: acknowledge wait");
      wr(4'h8, 4'hf);
      rc(4'hd, st(0));
      rc(4'hc, 4'h0);
      $display("done: clock stop");
      // master receive: own ack of 0 pulled onto the line at count 8
      wr(4'h8, 4'h3);
      wr(4'he, 4'h5);
      idle();
      rc(4'hd, st(8));
      chk({3'b000, sda_oe}, 4'h1);
      $display("done: receive acknowledge");
      end_of_test();
   end
endmodule

// file: sim/sio_bus_model.sv
// far bus station: pull-ups, clock stretch and acknowledge
`timescale 1ns/1ns
module sio_bus_model (
   input  wire logic rst,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   input  wire logic stretch,
   output logic      scl,
   output logic      sda
);
   int   rises;
   logic ack_drv = 1'b0; // known before the first clock fall
   // open drain with pull-ups, any party pulling low wins
   assign scl = ~scl_oe & ~stretch;
   assign sda = ~sda_oe & ~ack_drv;
   // count clock rises so the ninth bit can be found
   always @(posedge scl or posedge rst) begin
      if (rst) rises <= 0;
      else rises <= (rises == 9) ? 1 : rises + 1;
   end
   // pull data low through the ninth bit as acknowledge
   always @(negedge scl or posedge rst) begin
      if (rst) ack_drv <= 1'b0;
      else ack_drv <= (rises == 8);
   end
endmodule
